// ### inc/dsm_pkg.sv
// Constants, types and register map of the drive state sequencer.
package dsm_pkg;

   typedef enum logic [3:0] {
      ST_START    = 4'h1,
      ST_NOTREADY = 4'h2,
      ST_SWDIS    = 4'h3,
      ST_READY    = 4'h4,
      ST_SWON     = 4'h5,
      ST_OPER     = 4'h6,
      ST_QSTOP    = 4'h7,
      ST_FRA      = 4'h8,
      ST_FAULT    = 4'h9
   } dsm_state_e;

   localparam int         ADDR_W      = 4;
   localparam logic [3:0] REG_CMD     = 4'h0;
   localparam logic [3:0] REG_ACCESS  = 4'h4;
   localparam logic [3:0] REG_STATUS  = 4'h8;

   localparam int         CMD_LSB     = 0;
   localparam int         CH_LSB      = 4;
   localparam logic [2:0] CMD_SHUTDOWN  = 3'h1;
   localparam logic [2:0] CMD_SWITCH_ON = 3'h2;
   localparam logic [2:0] CMD_ENABLE_OP = 3'h3;
   localparam logic [2:0] CMD_DISABLE_OP = 3'h4;
   localparam logic [2:0] CMD_DIS_VOLT  = 3'h5;
   localparam logic [2:0] CMD_QSTOP     = 3'h6;
   localparam logic [2:0] CMD_FRESET    = 3'h7;
   localparam logic [1:0] CH_BUS      = 2'h0;
   localparam logic [1:0] CH_TOOL     = 2'h1;
   localparam logic [1:0] OWN_NONE    = 2'h0;
   localparam logic [1:0] OWN_BUS     = 2'h1;
   localparam logic [1:0] OWN_TOOL    = 2'h2;

   localparam int         LCI_ENABLE  = 0;
   localparam int         LCI_DISABLE = 1;
   localparam int         LCI_FRESET  = 2;
   localparam int         LCI_QSTOP   = 3;

   localparam int         ST_PWR_BIT  = 4;
   localparam int         ST_BRK_BIT  = 5;
   localparam int         ST_QS_BIT   = 6;
   localparam int         ST_HALT_BIT = 7;
   localparam int         ST_BLK_BIT  = 8;
   localparam int         ST_REJ_BIT  = 9;
   localparam int         ST_OWN_LSB  = 10;

   localparam dsm_state_e RST_STATE   = ST_START;
   localparam logic [1:0] RST_OWNER   = OWN_BUS;

   typedef struct packed {
      logic       safeOffInputA;
      logic       safeOffInputB;
      logic       halt;
      logic       positiveLimitSwitch;
      logic       negativeLimitSwitch;
      logic       refSwitch;
      logic       underVoltage;
      logic       errClass1;
      logic       errClass2;
      logic       errClass3;
      logic       errClass4;
      logic       errCause;
      logic       elecInitDone;
      logic       paramInitDone;
      logic       notReadyFail;
      logic       quickStopDone;
      logic [3:0] localConfigInputs;
   } dsm_pins_s;

endpackage

// ### src/dsm_sync.sv
// Two-stage synchroniser for a bundle of asynchronous levels.
`timescale 1ns/1ns
module dsm_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } dsm_sync_s;

   dsm_sync_s r;
   dsm_sync_s n;

   always_comb begin
      n        = r;
      n.stage1 = d;
      n.stage2 = r.stage1;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign q = r.stage2;
endmodule // dsm_sync

// ### src/dsm_access_ctrl.sv
// Drive operating-state sequencer with exclusive access arbitration.
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
module dsm_access_ctrl (
   input  wire logic                  clk,
   input  wire logic                  srst,
   input  wire logic [3:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   output logic      [31:0]           avs_readdata,
   output logic                       avs_waitrequest,
   input  wire dsm_pkg::dsm_pins_s    pinsAsync,
   output logic      [3:0]            operState,
   output logic                       powerStageOn,
   output logic                       brakeRelease,
   output logic                       quickStopRun,
   output logic                       haltRun,
   output logic                       motionBlock,
   output logic                       rejectFlag
);
   localparam int PW = $bits(dsm_pkg::dsm_pins_s);

   typedef struct packed {
      dsm_pkg::dsm_state_e state;
      logic                hardErr;
      logic                viaBus;
      logic                stuck;
      logic [1:0]          owner;
      logic [3:0]          lciPrev;
      logic                waitReq;
      logic [31:0]         rdata;
      logic                pwr;
      logic                brk;
      logic                qs;
      logic                haltPulse;
      logic                blk;
      logic                rej;
   } dsm_ctrl_s;

   dsm_ctrl_s          r;
   dsm_ctrl_s          n;
   logic [PW-1:0]      pinsBits;
   dsm_pkg::dsm_pins_s p;

   dsm_sync #(.W(PW)) u_sync (
      .clk  (clk),
      .srst (srst),
      .d    (pinsAsync),
      .q    (pinsBits)
   );
   assign p = dsm_pkg::dsm_pins_s'(pinsBits);

   logic       wrAcc;
   logic       wrCmd;
   logic [2:0] cmdCode;
   logic [1:0] cmdCh;
   logic       cmdGo;
   logic       localOk;
   logic [3:0] lciRise;
   logic [3:0] lciReq;
   logic       stoHigh;
   logic       stoLow;
   logic       hardCause;
   logic       reqEnable;
   logic       reqDisable;
   logic       fReset;
   logic       qStop;
   logic       isCmd;

   // ----------------------------------------------------------------
   // Request decode
   // ----------------------------------------------------------------
   always_comb begin
      wrAcc   = avs_write && !r.waitReq;
      wrCmd   = wrAcc && avs_address == dsm_pkg::REG_CMD;
      cmdCode = avs_writedata[dsm_pkg::CMD_LSB +: 3];
      cmdCh   = avs_writedata[dsm_pkg::CH_LSB +: 2];
      // A channel is shut out while another holds the claim.
      cmdGo   = wrCmd && ((cmdCh == dsm_pkg::CH_BUS
                  && r.owner != dsm_pkg::OWN_TOOL)
                || (cmdCh == dsm_pkg::CH_TOOL
                  && r.owner != dsm_pkg::OWN_BUS));
      isCmd   = cmdGo;
      localOk = r.owner == dsm_pkg::OWN_NONE;
      lciRise = p.localConfigInputs & ~r.lciPrev;
      lciReq  = localOk ? lciRise : 4'h0;
      stoHigh = p.safeOffInputA && p.safeOffInputB;
      stoLow  = !p.safeOffInputA && !p.safeOffInputB;
      // Either source suffices for reset and quick stop; enable and disable come from local inputs only.
      reqEnable  = lciReq[dsm_pkg::LCI_ENABLE];
      reqDisable = lciReq[dsm_pkg::LCI_DISABLE];
      fReset     = lciReq[dsm_pkg::LCI_FRESET]
                   || (isCmd && cmdCode == dsm_pkg::CMD_FRESET);
      qStop      = lciReq[dsm_pkg::LCI_QSTOP]
                   || (isCmd && cmdCode == dsm_pkg::CMD_QSTOP);
      hardCause  = p.errClass3 || p.errClass4
                   || (stoLow && (r.state == dsm_pkg::ST_SWON
                   || r.state == dsm_pkg::ST_OPER
                   || r.state == dsm_pkg::ST_QSTOP));
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      n           = r;
      n.lciPrev   = p.localConfigInputs;
      n.haltPulse = 1'b0;
      n.waitReq   = !((avs_read || avs_write) && r.waitReq);
      if ((wrCmd && !cmdGo) || (lciRise != 4'h0 && !localOk)) begin
         n.rej = 1'b1;
      end else if (wrAcc && avs_address == dsm_pkg::REG_STATUS
                   && avs_writedata[dsm_pkg::ST_REJ_BIT]) begin
         n.rej = 1'b0;
      end
      if (wrAcc && avs_address == dsm_pkg::REG_ACCESS) begin
         n.owner = avs_writedata[1:0];
      end
      if (p.notReadyFail && (r.state == dsm_pkg::ST_START
          || r.state == dsm_pkg::ST_NOTREADY)) begin
         n.stuck = 1'b1;
      end

      // Class 2 to 4 errors are looked at before any command.
      if (r.state != dsm_pkg::ST_START && r.state != dsm_pkg::ST_NOTREADY
          && r.state != dsm_pkg::ST_FAULT && r.state != dsm_pkg::ST_FRA
          && (hardCause || p.errClass2)) begin
         n.state   = dsm_pkg::ST_FRA;
         n.hardErr = hardCause;
      end else begin
         case (r.state)
            dsm_pkg::ST_START: begin
               if (p.elecInitDone) n.state = dsm_pkg::ST_NOTREADY;
            end
            dsm_pkg::ST_NOTREADY: begin
               if (p.paramInitDone && !p.notReadyFail && !r.stuck) begin
                  n.state = dsm_pkg::ST_SWDIS;
               end
            end
            dsm_pkg::ST_SWDIS: begin
               if ((!p.underVoltage && stoHigh)
                   || (isCmd && cmdCode == dsm_pkg::CMD_SHUTDOWN)) begin
                  n.state = dsm_pkg::ST_READY;
               end
            end
            dsm_pkg::ST_READY: begin
               if (p.underVoltage || stoLow
                   || (isCmd && cmdCode == dsm_pkg::CMD_DIS_VOLT)) begin
                  n.state = dsm_pkg::ST_SWDIS;
               end else if (isCmd && cmdCode == dsm_pkg::CMD_SWITCH_ON) begin
                  n.state  = dsm_pkg::ST_SWON;
                  n.viaBus = 1'b1;
               end else if (reqEnable) begin
                  n.state  = dsm_pkg::ST_SWON;
                  n.viaBus = 1'b0;
               end
            end
            dsm_pkg::ST_SWON: begin
               if (reqDisable
                   || (isCmd && cmdCode == dsm_pkg::CMD_DIS_VOLT)) begin
                  n.state = dsm_pkg::ST_SWDIS;
               end else if (isCmd && cmdCode == dsm_pkg::CMD_SHUTDOWN) begin
                  n.state = dsm_pkg::ST_READY;
               end else if (!r.viaBus
                   || (isCmd && cmdCode == dsm_pkg::CMD_ENABLE_OP)) begin
                  n.state = dsm_pkg::ST_OPER;
               end
            end
            dsm_pkg::ST_OPER: begin
               if (reqDisable
                   || (isCmd && cmdCode == dsm_pkg::CMD_DIS_VOLT)) begin
                  n.state = dsm_pkg::ST_SWDIS;
               end else if (isCmd && cmdCode == dsm_pkg::CMD_SHUTDOWN) begin
                  n.state = dsm_pkg::ST_READY;
               end else if (p.errClass1 || qStop) begin
                  n.state = dsm_pkg::ST_QSTOP;
               end else if (isCmd && cmdCode == dsm_pkg::CMD_DISABLE_OP) begin
                  n.state     = dsm_pkg::ST_SWON;
                  n.haltPulse = 1'b1;
                  n.viaBus    = 1'b1;
               end
            end
            dsm_pkg::ST_QSTOP: begin
               if (reqDisable
                   || (isCmd && cmdCode == dsm_pkg::CMD_DIS_VOLT)) begin
                  n.state = dsm_pkg::ST_SWDIS;
               end else if (fReset
                   || (isCmd && cmdCode == dsm_pkg::CMD_ENABLE_OP)) begin
                  n.state = dsm_pkg::ST_OPER;
               end
            end
            dsm_pkg::ST_FRA: begin
               if (r.hardErr || p.quickStopDone) begin
                  n.state = dsm_pkg::ST_FAULT;
               end
            end
            dsm_pkg::ST_FAULT: begin
               if (fReset && !p.errCause) begin
                  n.state   = dsm_pkg::ST_SWDIS;
                  n.hardErr = 1'b0;
               end
            end
            default: n.state = dsm_pkg::ST_START;
         endcase
      end

      // Power stage drops at once on a hard fault; brake held otherwise.
      n.pwr = n.state == dsm_pkg::ST_OPER || n.state == dsm_pkg::ST_QSTOP
              || (n.state == dsm_pkg::ST_FRA && !n.hardErr);
      n.brk = n.state == dsm_pkg::ST_OPER;
      n.qs  = n.state == dsm_pkg::ST_QSTOP
              || (n.state == dsm_pkg::ST_FRA && !n.hardErr);
      n.blk = p.halt || p.positiveLimitSwitch
              || p.negativeLimitSwitch;

      if (avs_read && r.waitReq) begin
         n.rdata = 32'h0;
         case (avs_address)
            dsm_pkg::REG_ACCESS: n.rdata[1:0] = r.owner;
            dsm_pkg::REG_STATUS: begin
               n.rdata[3:0] = r.state;
               n.rdata[dsm_pkg::ST_PWR_BIT]  = r.pwr;
               n.rdata[dsm_pkg::ST_BRK_BIT]  = r.brk;
               n.rdata[dsm_pkg::ST_QS_BIT]   = r.qs;
               n.rdata[dsm_pkg::ST_HALT_BIT] = p.halt;
               n.rdata[dsm_pkg::ST_BLK_BIT]  = p.refSwitch;
               n.rdata[dsm_pkg::ST_REJ_BIT]  = r.rej;
               n.rdata[dsm_pkg::ST_OWN_LSB +: 2] = r.owner;
            end
            default: n.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         r         <= '0;
         r.state   <= dsm_pkg::RST_STATE;
         r.owner   <= dsm_pkg::RST_OWNER;
         r.waitReq <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign avs_readdata    = r.rdata;
   assign avs_waitrequest = r.waitReq;
   assign operState       = r.state;
   assign powerStageOn    = r.pwr;
   assign brakeRelease    = r.brk;
   assign quickStopRun    = r.qs;
   assign haltRun         = r.haltPulse;
   assign motionBlock     = r.blk;
   assign rejectFlag      = r.rej;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_disOp;
      r.state == dsm_pkg::ST_OPER && isCmd && !hardCause && !p.errClass2
      && cmdCode == dsm_pkg::CMD_DISABLE_OP && !reqDisable && !qStop
      && !p.errClass1;
   endsequence

   a_tool_lock: assert property (wrCmd && cmdCh == dsm_pkg::CH_BUS
      && r.owner == dsm_pkg::OWN_TOOL |=> rejectFlag)
      else $error("bus command accepted under tool claim");
   a_local_lock: assert property (!localOk && lciRise != 4'h0
      |=> rejectFlag)
      else $error("locked local input not flagged");
   a_halt_path: assert property ($rose(p.halt) |=> motionBlock)
      else $error("halt not effective");
   a_state_range: assert property (operState >= 4'h1
      && operState <= 4'h9)
      else $error("operating state out of range");
   a_stuck_hold: assert property (r.stuck && r.state != dsm_pkg::ST_START
      |=> operState == dsm_pkg::ST_NOTREADY)
      else $error("not-ready left without power cycle");
   a_dis_op_seq: assert property (s_disOp
      |=> haltRun && !powerStageOn && !brakeRelease
      ##1 operState == dsm_pkg::ST_SWON)
      else $error("disable operation sequence wrong");
   a_hard_power: assert property (r.state == dsm_pkg::ST_OPER && hardCause
      |=> !powerStageOn ##1 operState == dsm_pkg::ST_FAULT)
      else $error("power stage not cut on hard fault");
   a_err_first: assert property (r.state >= dsm_pkg::ST_SWDIS
      && r.state <= dsm_pkg::ST_QSTOP
      && p.errClass2 |=> operState == dsm_pkg::ST_FRA)
      else $error("error lost against command");
   a_fault_exit: assert property (r.state == dsm_pkg::ST_FAULT
      && $changed(r.state) == 1'b0 && p.errCause
      |=> operState == dsm_pkg::ST_FAULT)
      else $error("fault left with cause present");
   a_qs_reset: assert property (r.state == dsm_pkg::ST_QSTOP && fReset
      && !hardCause && !p.errClass2 && !reqDisable && !(isCmd
      && cmdCode == dsm_pkg::CMD_DIS_VOLT)
      |=> operState == dsm_pkg::ST_OPER)
      else $error("quick stop reset missed");
endmodule // dsm_access_ctrl

// ### tb/dsm_far_side.sv
// Far-side model: local inputs, safety inputs and error sources.
`timescale 1ns/1ns
module dsm_far_side (
   input  wire logic          clk,
   output dsm_pkg::dsm_pins_s pins
);
   // ---------------------------------------------
   // Pin drivers
   // ---------------------------------------------
   // Every pin changes just after a rising edge.
   initial begin
      pins = '0;
   end

   task automatic pulse_local(input int idx);
      @(posedge clk);
      pins.localConfigInputs[idx] <= 1'b1;
      repeat (4) @(posedge clk);
      pins.localConfigInputs[idx] <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   task automatic set_safe_off(input logic lvl);
      pins.safeOffInputA <= lvl;
      pins.safeOffInputB <= lvl;
   endtask

   task automatic raise_error(input int cls);
      pins.errCause  <= (cls != 0);
      pins.errClass1 <= (cls == 1);
      pins.errClass2 <= (cls == 2);
      pins.errClass3 <= (cls == 3);
      pins.errClass4 <= (cls == 4);
   endtask

   // A slow answer is modelled by a longer lag.
   task automatic finish_quick_stop(input int lag);
      repeat (lag) @(posedge clk);
      pins.quickStopDone <= 1'b1;
   endtask

   // The cause is removed before the reset request is made.
   task automatic fault_reset();
      raise_error(0);
      pins.quickStopDone <= 1'b0;
      pulse_local(dsm_pkg::LCI_FRESET);
   endtask
endmodule // dsm_far_side

// ### tb/drive_state_machine_access_ctrl_tb.sv
// Self-checking bench of the drive state sequencer.
`timescale 1ns/1ns
module drive_state_machine_access_ctrl_tb;
   logic               clk;
   logic               srst;
   logic [3:0]         avs_address;
   logic               avs_read;
   logic               avs_write;
   logic [31:0]        avs_writedata;
   logic [31:0]        avs_readdata;
   logic               avs_waitrequest;
   dsm_pkg::dsm_pins_s pins;
   logic [3:0]         operState;
   logic               powerStageOn;
   logic               brakeRelease;
   logic               quickStopRun;
   logic               haltRun;
   logic               motionBlock;
   logic               rejectFlag;
   logic [31:0]        rd;
   int                 errTotal = 0;
   int                 samplesChecked = 0;
   int                 cycles = 0;

   dsm_access_ctrl u_dut (.clk(clk), .srst(srst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .pinsAsync(pins), .operState(operState),
      .powerStageOn(powerStageOn), .brakeRelease(brakeRelease),
      .quickStopRun(quickStopRun), .haltRun(haltRun),
      .motionBlock(motionBlock), .rejectFlag(rejectFlag));
   dsm_far_side u_far (.clk(clk), .pins(pins));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errTotal++;
         $display("Error at %0t: run timed out", $time);
         completeRun();
      end
   end

   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic completeRun();
      $display("checks %0d errors %0d", samplesChecked, errTotal);
      if (errTotal == 0 && samplesChecked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      samplesChecked++;
      if (got !== exp) begin
         errTotal++;
         $display("Error at %0t: %s got %0h", $time, what, got);
      end
   endtask

   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= ~wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge clk);
      chk({31'h0, n < 20}, 32'h1, "bus answer");
   endtask

   task automatic bcmd(input logic [1:0] ch, input logic [2:0] c);
      bus(1'b1, dsm_pkg::REG_CMD, {26'h0, ch, 1'b0, c});
   endtask

   // The state is looked at before the first edge, so that a state that
   // stands for one cycle only is not missed.
   task automatic wait_state(input logic [3:0] exp);
      int n;
      n = 0;
      while (operState !== exp && n < 40) begin
         @(posedge clk);
         n++;
      end
      chk({28'h0, operState}, {28'h0, exp}, "state");
   endtask

   task automatic hold_state(input logic [3:0] exp);
      repeat (12) @(posedge clk);
      chk({28'h0, operState}, {28'h0, exp}, "state held");
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_start();
      chk({26'h0, operState, powerStageOn, rejectFlag}, 32'h0000_0004,
          "rst");
      bus(1'b0, dsm_pkg::REG_STATUS, 32'h0);
      chk(rd, 32'h0000_0401, "status after reset");
      bus(1'b0, 4'hC, 32'h0);
      chk(rd, 32'h0, "unmapped read");
      u_far.pins.elecInitDone <= 1'b1;
      wait_state(dsm_pkg::ST_NOTREADY);
      u_far.pins.paramInitDone <= 1'b1;
      wait_state(dsm_pkg::ST_SWDIS);
      hold_state(dsm_pkg::ST_SWDIS);
      u_far.set_safe_off(1'b1);
      wait_state(dsm_pkg::ST_READY);
      u_far.pins.underVoltage <= 1'b1;
      wait_state(dsm_pkg::ST_SWDIS);
      u_far.pins.underVoltage <= 1'b0;
      wait_state(dsm_pkg::ST_READY);
      $display("test start done");
   endtask

   task automatic t_bus();
      bcmd(dsm_pkg::CH_BUS, dsm_pkg::CMD_SWITCH_ON);
      wait_state(dsm_pkg::ST_SWON);
      hold_state(dsm_pkg::ST_SWON);
      bcmd(dsm_pkg::CH_BUS, dsm_pkg::CMD_ENABLE_OP);
      wait_state(dsm_pkg::ST_OPER);
      chk({30'h0, powerStageOn, brakeRelease}, 32'h3, "power on");
      avs_address   <= dsm_pkg::REG_CMD;
      avs_writedata <= {26'h0, dsm_pkg::CH_BUS, 1'b0,
                        dsm_pkg::CMD_DISABLE_OP};
      avs_write     <= 1'b1;
      rd = 32'h0;
      repeat (10) begin
         @(posedge clk);
         if (avs_waitrequest === 1'b0) avs_write <= 1'b0;
         if (haltRun === 1'b1) rd = 32'h1;
      end
      chk(rd, 32'h1, "halt pulse");
      bcmd(dsm_pkg::CH_BUS, dsm_pkg::CMD_SHUTDOWN);
      wait_state(dsm_pkg::ST_READY);
      $display("test bus done");
   endtask

   task automatic t_access();
      bus(1'b1, dsm_pkg::REG_ACCESS, {30'h0, dsm_pkg::OWN_TOOL});
      bus(1'b0, dsm_pkg::REG_ACCESS, 32'h0);
      chk(rd, {30'h0, dsm_pkg::OWN_TOOL}, "owner");
      bcmd(dsm_pkg::CH_BUS, dsm_pkg::CMD_SWITCH_ON);
      hold_state(dsm_pkg::ST_READY);
      chk({31'h0, rejectFlag}, 32'h1, "bus refused");
      bus(1'b1, dsm_pkg::REG_STATUS, 32'h0000_0200);
      chk({31'h0, rejectFlag}, 32'h0, "reject cleared");
      u_far.pulse_local(dsm_pkg::LCI_ENABLE);
      hold_state(dsm_pkg::ST_READY);
      chk({31'h0, rejectFlag}, 32'h1, "local refused");
      u_far.pins.positiveLimitSwitch <= 1'b1;
      repeat (5) @(posedge clk);
      chk({31'h0, motionBlock}, 32'h1, "limit acts");
      u_far.pins.positiveLimitSwitch <= 1'b0;
      u_far.pins.halt                <= 1'b1;
      repeat (5) @(posedge clk);
      chk({31'h0, motionBlock}, 32'h1, "halt acts");
      u_far.pins.halt <= 1'b0;
      repeat (5) @(posedge clk);
      chk({31'h0, motionBlock}, 32'h0, "limit gone");
      bcmd(dsm_pkg::CH_TOOL, dsm_pkg::CMD_DIS_VOLT);
      wait_state(dsm_pkg::ST_SWDIS);
      wait_state(dsm_pkg::ST_READY);
      bus(1'b1, dsm_pkg::REG_ACCESS, {30'h0, dsm_pkg::OWN_NONE});
      $display("test access done");
   endtask

   task automatic t_local();
      u_far.pulse_local(dsm_pkg::LCI_ENABLE);
      wait_state(dsm_pkg::ST_OPER);
      chk({31'h0, powerStageOn}, 32'h1, "local power on");
      u_far.pulse_local(dsm_pkg::LCI_DISABLE);
      wait_state(dsm_pkg::ST_READY);
      chk({31'h0, powerStageOn}, 32'h0, "local power off");
      u_far.pulse_local(dsm_pkg::LCI_ENABLE);
      wait_state(dsm_pkg::ST_OPER);
      u_far.raise_error(1);
      wait_state(dsm_pkg::ST_QSTOP);
      chk({31'h0, quickStopRun}, 32'h1, "quick stop");
      u_far.fault_reset();
      wait_state(dsm_pkg::ST_OPER);
      $display("test local done");
   endtask

   task automatic t_fault(input int cls);
      u_far.raise_error(cls);
      wait_state(dsm_pkg::ST_FRA);
      chk({30'h0, powerStageOn, quickStopRun},
          (cls == 2) ? 32'h3 : 32'h0, "reaction");
      if (cls == 2) begin
         hold_state(dsm_pkg::ST_FRA);
         u_far.finish_quick_stop(6);
      end
      wait_state(dsm_pkg::ST_FAULT);
      chk({31'h0, powerStageOn}, 32'h0, "fault power");
      u_far.set_safe_off(1'b0);
      u_far.pulse_local(dsm_pkg::LCI_FRESET);
      hold_state(dsm_pkg::ST_FAULT);
      u_far.fault_reset();
      wait_state(dsm_pkg::ST_SWDIS);
      u_far.set_safe_off(1'b1);
      wait_state(dsm_pkg::ST_READY);
      u_far.pulse_local(dsm_pkg::LCI_ENABLE);
      wait_state(dsm_pkg::ST_OPER);
      $display("test fault done");
   endtask

   task automatic t_notready();
      u_far.pins.notReadyFail  <= 1'b1;
      u_far.pins.paramInitDone <= 1'b0;
      srst <= 1'b1;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      wait_state(dsm_pkg::ST_NOTREADY);
      u_far.pins.paramInitDone <= 1'b1;
      u_far.pins.notReadyFail  <= 1'b0;
      bcmd(dsm_pkg::CH_BUS, dsm_pkg::CMD_FRESET);
      hold_state(dsm_pkg::ST_NOTREADY);
      $display("test notready done");
   endtask

   initial begin
      srst          = 1'b1;
      avs_address   = 4'h0;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_writedata = 32'h0;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_start();
      t_bus();
      t_access();
      t_local();
      t_fault(2);
      t_fault(3);
      t_notready();
      completeRun();
   end
endmodule // drive_state_machine_access_ctrl_tb
